// ==== logic/contact_sync.v ====
// two-stage synchroniser for a group of external contact inputs
`timescale 1ns/1ps
`default_nettype none

module contact_sync #(
   parameter WIDTH = 4
) (
   input  wire             ref_clk,
   input  wire             resetn,
   input  wire [WIDTH-1:0] rawIn,
   output reg  [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q  <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_q  <= rawIn;
         syncOut <= meta_q;
      end
   end

endmodule

`default_nettype wire

// ==== logic/servo_mode_map.vh ====
// register offsets, field positions, alarm codes and timing for the servo mode and alarm block
`ifndef SERVO_MODE_MAP_VH
`define SERVO_MODE_MAP_VH

// register byte offsets
`define OFF_CTRL       8'h00
`define OFF_SPDLIM     8'h04
`define OFF_STATUS     8'h08
`define OFF_IRQ_STAT   8'h0c
`define OFF_IRQ_CLR    8'h10
`define OFF_IRQ_EN     8'h14
`define OFF_CMD        8'h18

// control register fields
`define CTRL_CHG_MODE  0
`define CTRL_INCR_POS  1
`define CTRL_RESET     32'h0000_0000
`define SPDLIM_RESET   16'h0000

// command register fields (write one to act)
`define CMD_SET_BUTTON 0
`define CMD_HOME_DONE  1

// status register fields
`define ST_POS_MODE    0
`define ST_ALARM       1
`define ST_HOME_VALID  2
`define ST_BASE_EN     3
`define ST_LIMITING    4
`define ST_CODE_LSB    8

// interrupt bits
`define IRQ_ALARM      0
`define IRQ_CLEARED    1
`define IRQ_MODE_CHG   2
`define IRQ_W          3

// alarm codes
`define AL_NONE        8'h00
`define AL_UNDERVOLT   8'h10
`define AL_REGEN       8'h30
`define AL_OVERCURRENT 8'h32
`define AL_OVERLOAD1   8'h50
`define AL_OVERLOAD2   8'h51

// control supply outage time that forces undervoltage, in ms, and clock in kHz
`define OUTAGE_MS      60
`define CLK_KHZ        125000
`define OUTAGE_CYCLES  (`OUTAGE_MS * `CLK_KHZ)

`endif

// ==== logic/servo_mode_switch_alarm.v ====
// speed limit choice, torque/position change and alarm handling with an ahb-lite register port
//
// Function
// - torque mode limit: analog if select 0, else internal
// - flag speed limiting when speed reaches selected limit
// - switch 0 gives torque, 1 gives position control
// - mode change only applied at zero speed
// - toggle away from zero speed is ignored
// - ignored toggle stays ignored after later stop
// - clear droop count on position to torque change
// - any alarm shuts power stage off at once
// - clear alarm by power cycle, set button, reset edge
// - no clear while the alarm cause persists
// - distinct codes for overcurrent, overload 1, overload 2
// - distinct code for regenerative fault
// - undervoltage after long control supply outage restores
// - undervoltage on bus drop while drive enabled
// - incremental mode loses home on alarm
`timescale 1ns/1ps
`default_nettype none
`include "servo_mode_map.vh"

module servo_mode_switch_alarm #(
   parameter SPD_W         = 16,
   parameter OUTAGE_CYCLES = `OUTAGE_CYCLES
) (
   input  wire             ref_clk,
   input  wire             resetn,
   // ahb-lite slave
   input  wire             hsel,
   input  wire [7:0]       haddr,
   input  wire [1:0]       htrans,
   input  wire             hwrite,
   input  wire [2:0]       hsize,
   input  wire [31:0]      hwdata,
   input  wire             hready,
   output reg  [31:0]      hrdata,
   output reg              hreadyout,
   output reg              hresp,
   // external contacts
   input  wire             speedSelectBit0,
   input  wire             controlModeSwitch,
   input  wire             alarmResetInput,
   input  wire             driveEnableInput,
   // internal monitors
   input  wire             zeroSpeedFlag,
   input  wire             busUnderVolt,
   input  wire             ctrlPowerGood,
   input  wire             overCurrent,
   input  wire             overload1,
   input  wire             overload2,
   input  wire             regenFault,
   input  wire [SPD_W-1:0] motorSpeed,
   input  wire [SPD_W-1:0] analogSpeedLimit,
   // outputs
   output reg  [SPD_W-1:0] speedLimitValue,
   output reg              speedLimitingFlag,
   output reg              positionMode,
   output reg              droopClear,
   output reg              baseCircuitEn,
   output reg              homeValid,
   output reg              alarmActive,
   output reg  [7:0]       alarmCode,
   output reg              irq
);

   // synchronised contacts
   wire [3:0] contactSync;
   wire       selSync;
   wire       modeSwSync;
   wire       resetSync;
   wire       driveSync;

   // registers
   reg [31:0]        ctrl_q;
   reg [SPD_W-1:0]   spdLimit_q;
   reg [`IRQ_W-1:0]  irqStat_q;
   reg [`IRQ_W-1:0]  irqEn_q;
   reg [`IRQ_W-1:0]  irqStat_d;

   // bus data phase
   reg               wrPend_q;
   reg [7:0]         wrAddr_q;

   // contact history and supply outage tracking
   reg               resetPrev_q;
   reg               modeSwPrev_q;
   reg [31:0]        outageCnt_q;
   reg               longOutage_q;
   reg               powerPrev_q;

   // alarm decision
   reg [7:0]         causeCode;
   reg               causeStill;
   reg [7:0]         alarmCode_d;
   reg               alarmActive_d;
   reg               positionMode_d;

   wire addrPhase;
   wire wrData;
   wire resetRise;
   wire setPress;
   wire homeDone;
   wire modeToggle;
   wire outageRestore;
   wire clearReq;
   wire modeChange;
   wire [SPD_W-1:0] limitSel;

   // contacts go through two flops before any use
   contact_sync #(
      .WIDTH   (4)
   ) u_contact_sync (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .rawIn   ({driveEnableInput, alarmResetInput, controlModeSwitch, speedSelectBit0}),
      .syncOut (contactSync)
   );

   assign selSync    = contactSync[0];
   assign modeSwSync = contactSync[1];
   assign resetSync  = contactSync[2];
   assign driveSync  = contactSync[3];

   // bus strobes and one-cycle command pulses
   assign addrPhase  = hsel && htrans[1] && hready;
   assign wrData     = wrPend_q;
   assign setPress   = wrData && (wrAddr_q == `OFF_CMD) && hwdata[`CMD_SET_BUTTON];
   assign homeDone   = wrData && (wrAddr_q == `OFF_CMD) && hwdata[`CMD_HOME_DONE];

   // off-to-on edge taken from the synchronised reset contact
   assign resetRise  = resetSync && !resetPrev_q;
   assign modeToggle = modeSwSync != modeSwPrev_q;

   // supply back after an outage at least as long as the limit
   assign outageRestore = ctrlPowerGood && !powerPrev_q && longOutage_q;

   // select 0 picks the analog limit, 1 the internal one
   assign limitSel = selSync ? spdLimit_q : analogSpeedLimit;

   // cause detection with fixed priority and distinct codes
   always @*
   begin
      causeCode = `AL_NONE;
      if (overCurrent)
         causeCode = `AL_OVERCURRENT;
      else if (overload1)
         causeCode = `AL_OVERLOAD1;
      else if (overload2)
         causeCode = `AL_OVERLOAD2;
      else if (regenFault)
         causeCode = `AL_REGEN;
      else if (outageRestore || (busUnderVolt && driveSync))
         causeCode = `AL_UNDERVOLT;
   end

   // is the cause of the latched alarm still there
   always @*
   begin
      case (alarmCode)
         `AL_OVERCURRENT: causeStill = overCurrent;
         `AL_OVERLOAD1:   causeStill = overload1;
         `AL_OVERLOAD2:   causeStill = overload2;
         `AL_REGEN:       causeStill = regenFault;
         `AL_UNDERVOLT:   causeStill = busUnderVolt || !ctrlPowerGood;
         default:         causeStill = 1'b0;
      endcase
   end

   // clearing needs a reset path and a removed cause
   assign clearReq = alarmActive && (resetRise || setPress) && !causeStill;

   // alarm latch: first cause wins, cleared only by request
   always @*
   begin
      alarmActive_d = alarmActive;
      alarmCode_d   = alarmCode;
      if (!alarmActive && (causeCode != `AL_NONE))
      begin
         alarmActive_d = 1'b1;
         alarmCode_d   = causeCode;
      end
      else if (clearReq)
      begin
         alarmActive_d = 1'b0;
         alarmCode_d   = `AL_NONE;
      end
   end

   // mode follows a switch edge only if seen at zero speed
   always @*
   begin
      positionMode_d = positionMode;
      if (!ctrl_q[`CTRL_CHG_MODE])
         positionMode_d = 1'b0;
      else if (modeToggle && zeroSpeedFlag)
         positionMode_d = modeSwSync;
   end

   assign modeChange = positionMode_d != positionMode;

   // interrupt status: set beats clear
   always @*
   begin
      irqStat_d = irqStat_q;
      if (wrData && (wrAddr_q == `OFF_IRQ_CLR))
         irqStat_d = irqStat_d & ~hwdata[`IRQ_W-1:0];
      if (alarmActive_d && !alarmActive)
         irqStat_d[`IRQ_ALARM] = 1'b1;
      if (clearReq)
         irqStat_d[`IRQ_CLEARED] = 1'b1;
      if (modeChange)
         irqStat_d[`IRQ_MODE_CHG] = 1'b1;
   end

   // ahb-lite slave, zero wait states, always okay
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hreadyout  <= 1'b0;
         hresp      <= 1'b0;
         hrdata     <= 32'h0000_0000;
         wrPend_q   <= 1'b0;
         wrAddr_q   <= 8'h00;
         ctrl_q     <= `CTRL_RESET;
         spdLimit_q <= `SPDLIM_RESET;
         irqEn_q    <= {`IRQ_W{1'b0}};
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wrPend_q  <= addrPhase && hwrite;
         if (addrPhase)
            wrAddr_q <= haddr;
         // read data is fetched at the address phase edge
         if (addrPhase && !hwrite)
         begin
            case (haddr)
               `OFF_CTRL:     hrdata <= ctrl_q;
               `OFF_SPDLIM:   hrdata <= {{(32-SPD_W){1'b0}}, spdLimit_q};
               `OFF_STATUS:   hrdata <= {16'h0000, alarmCode, 3'b000,
                                         speedLimitingFlag, baseCircuitEn,
                                         homeValid, alarmActive, positionMode};
               `OFF_IRQ_STAT: hrdata <= {{(32-`IRQ_W){1'b0}}, irqStat_q};
               `OFF_IRQ_EN:   hrdata <= {{(32-`IRQ_W){1'b0}}, irqEn_q};
               default:       hrdata <= 32'h0000_0000;
            endcase
         end
         // writes land at the end of the data phase
         if (wrData)
         begin
            case (wrAddr_q)
               `OFF_CTRL:   ctrl_q     <= {30'h0000_0000, hwdata[1:0]};
               `OFF_SPDLIM: spdLimit_q <= hwdata[SPD_W-1:0];
               `OFF_IRQ_EN: irqEn_q    <= hwdata[`IRQ_W-1:0];
               default:     ;
            endcase
         end
      end
   end

   // contact history and control supply outage timer
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         resetPrev_q  <= 1'b0;
         modeSwPrev_q <= 1'b0;
         powerPrev_q  <= 1'b1;
         outageCnt_q  <= 32'h0000_0000;
         longOutage_q <= 1'b0;
      end
      else
      begin
         resetPrev_q  <= resetSync;
         modeSwPrev_q <= modeSwSync;
         powerPrev_q  <= ctrlPowerGood;
         if (ctrlPowerGood)
         begin
            outageCnt_q  <= 32'h0000_0000;
            longOutage_q <= 1'b0;
         end
         else if (outageCnt_q < OUTAGE_CYCLES)
         begin
            outageCnt_q <= outageCnt_q + 32'h0000_0001;
            if (outageCnt_q == OUTAGE_CYCLES - 1)
               longOutage_q <= 1'b1;
         end
      end
   end

   // alarm, power stage, home and mode state
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         alarmActive   <= 1'b0;
         alarmCode     <= `AL_NONE;
         baseCircuitEn <= 1'b0;
         homeValid     <= 1'b0;
         positionMode  <= 1'b0;
         droopClear    <= 1'b0;
         irqStat_q     <= {`IRQ_W{1'b0}};
         irq           <= 1'b0;
      end
      else
      begin
         alarmActive <= alarmActive_d;
         alarmCode   <= alarmCode_d;
         // raw cause cuts the stage in the same edge as the latch
         baseCircuitEn <= driveSync && !alarmActive_d;
         // home lost on alarm in incremental mode, set by home return
         if (ctrl_q[`CTRL_INCR_POS] && alarmActive_d)
            homeValid <= 1'b0;
         else if (homeDone)
            homeValid <= 1'b1;
         positionMode <= positionMode_d;
         // one pulse when leaving position control
         droopClear <= positionMode && !positionMode_d;
         irqStat_q  <= irqStat_d;
         irq        <= |(irqStat_d & irqEn_q);
      end
   end

   // limit value and limiting flag, meaningful in torque mode
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         speedLimitValue   <= {SPD_W{1'b0}};
         speedLimitingFlag <= 1'b0;
      end
      else
      begin
         speedLimitValue   <= limitSel;
         speedLimitingFlag <= !positionMode && (motorSpeed >= limitSel);
      end
   end

endmodule

`default_nettype wire

// ==== tb/seq_ctrl_model.sv ====
// external sequence controller driving the drive enable contact
`timescale 1ns/1ps
`default_nettype none
module seq_ctrl_model #(
   parameter logic [3:0] DLY = 4'h3
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic wantOn,
   input  wire logic alarmActive,
   output var  logic driveEnableInput
);
   logic [3:0] waitCnt_q;
   // drop enable at once on alarm, re-enable after a settling delay
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         waitCnt_q <= 4'h0;
         driveEnableInput <= 1'b0;
      end
      else if (alarmActive || !wantOn)
      begin
         waitCnt_q <= 4'h0;
         driveEnableInput <= 1'b0;
      end
      else if (waitCnt_q < DLY)
         waitCnt_q <= waitCnt_q + 4'h1;
      else
         driveEnableInput <= 1'b1;
   end
endmodule
`default_nettype wire

// ==== tb/servo_checker_properties.sv ====
// port assertions for the servo mode and alarm block
`timescale 1ns/1ps
`default_nettype none
module servo_checker (
   input wire logic       ref_clk,
   input wire logic       resetn,
   input wire logic       overCurrent,
   input wire logic       overload1,
   input wire logic       overload2,
   input wire logic       regenFault,
   input wire logic       busUnderVolt,
   input wire logic       ctrlPowerGood,
   input wire logic       zeroSpeedFlag,
   input wire logic       positionMode,
   input wire logic       droopClear,
   input wire logic       baseCircuitEn,
   input wire logic       homeValid,
   input wire logic       alarmActive,
   input wire logic [7:0] alarmCode,
   input wire logic       speedLimitingFlag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // any alarm cause still present
   wire logic anyCause = overCurrent | overload1 | overload2 | regenFault | busUnderVolt
                         | !ctrlPowerGood;
   property p_trip; !alarmActive && overCurrent |=> alarmActive && !baseCircuitEn; endproperty
   a_trip: assert property (p_trip) else $error("power stage not cut on alarm");
   property p_off; alarmActive |-> !baseCircuitEn; endproperty
   a_off: assert property (p_off) else $error("power stage on during alarm");
   property p_oc; !alarmActive && overCurrent |=> alarmCode == 8'h32; endproperty
   a_oc: assert property (p_oc) else $error("wrong overcurrent code");
   property p_regen;
      !alarmActive && regenFault && !(overCurrent | overload1 | overload2) |=> alarmCode == 8'h30;
   endproperty
   a_regen: assert property (p_regen) else $error("wrong regenerative code");
   property p_hold; alarmActive && anyCause |=> alarmActive; endproperty
   a_hold: assert property (p_hold) else $error("alarm cleared with cause present");
   property p_mode; positionMode != $past(positionMode) |-> $past(zeroSpeedFlag); endproperty
   a_mode: assert property (p_mode) else $error("mode changed away from zero speed");
   property p_droop; $fell(positionMode) |-> droopClear || $past(droopClear); endproperty
   a_droop: assert property (p_droop) else $error("no droop clear on torque entry");
   property p_home; $rose(alarmActive) |-> !homeValid; endproperty
   a_home: assert property (p_home) else $error("home kept through alarm");
   property p_lim; positionMode && $past(positionMode) |-> !speedLimitingFlag; endproperty
   a_lim: assert property (p_lim) else $error("limiting flag in position mode");
   cover property ($rose(alarmActive));
   cover property ($fell(alarmActive));
   cover property ($fell(positionMode));
endmodule
bind servo_mode_switch_alarm servo_checker u_chk (.ref_clk, .resetn, .overCurrent, .overload1,
   .overload2, .regenFault, .busUnderVolt, .ctrlPowerGood, .zeroSpeedFlag, .positionMode,
   .droopClear, .baseCircuitEn, .homeValid, .alarmActive, .alarmCode, .speedLimitingFlag);
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the servo mode and alarm block
`timescale 1ns/1ps
`default_nettype none
`include "servo_mode_map.vh"
module tb_top;
   logic ref_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pend = 1'b0;
   logic speedSelectBit0 = 1'b0, controlModeSwitch = 1'b0, alarmResetInput = 1'b0;
   logic zeroSpeedFlag = 1'b1, ctrlPowerGood = 1'b1, wantOn = 1'b0;
   logic [4:0]  cause = 5'h00;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, got;
   logic [15:0] motorSpeed = 16'h0, analogSpeedLimit = 16'h0, spd, lim;
   logic [7:0]  codes [5] = '{8'h32, 8'h50, 8'h51, 8'h30, 8'h10};
   logic [31:0] qe [$], qm [$];
   logic [1:0]  qs [$];
   string       qn [$];
   int          failures = 0, total_checks = 0, cyc = 0, i, droopCnt = 0;
   wire  [31:0] hrdata;
   wire  [15:0] speedLimitValue;
   wire  [7:0]  alarmCode;
   wire         hreadyout, hresp, speedLimitingFlag, positionMode, droopClear, baseCircuitEn;
   wire         homeValid, alarmActive, irq, driveEnableInput;

   servo_mode_switch_alarm #(.OUTAGE_CYCLES(20)) u_dut (.ref_clk, .resetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .speedSelectBit0, .controlModeSwitch, .alarmResetInput, .driveEnableInput, .zeroSpeedFlag,
      .busUnderVolt(cause[4]), .ctrlPowerGood, .overCurrent(cause[0]), .overload1(cause[1]),
      .overload2(cause[2]), .regenFault(cause[3]), .motorSpeed, .analogSpeedLimit,
      .speedLimitValue, .speedLimitingFlag, .positionMode, .droopClear, .baseCircuitEn,
      .homeValid, .alarmActive, .alarmCode, .irq);
   seq_ctrl_model u_seq (.ref_clk, .resetn, .wantOn, .alarmActive, .driveEnableInput);

   always #4 ref_clk = ~ref_clk;

   task automatic test_done;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, m, g);
      total_checks++;
      if ((g & m) !== (e & m))
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e & m, g & m);
      end
   endtask

   // take the oldest note when a result appears; also the hang limit
   always @(posedge ref_clk)
   begin
      if (pend)
      begin
         if (qs[0] == 2'd0)
            chk("hresp", 32'h0, 32'h1, {31'h0, hresp});
         got = qs[0] == 2'd0 ? hrdata : qs[0] == 2'd1 ? {16'h0, speedLimitValue} :
               qs[0] == 2'd2 ? {31'h0, irq} : 32'(droopCnt);
         chk(qn.pop_front(), qe.pop_front(), qm.pop_front(), got);
         void'(qs.pop_front());
      end
      // count droop clear pulses for the mode change check
      droopCnt += int'(droopClear === 1'b1);
      cyc++;
      if (cyc > 5000)
      begin
         failures++;
         test_done();
      end
   end

   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one ahb-lite single transfer, read data taken by the watcher
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      pend <= !wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      pend <= 1'b0;
   endtask

   task automatic note(input logic [1:0] s, input logic [31:0] e, m, input string n);
      qs.push_back(s);
      qe.push_back(e);
      qm.push_back(m);
      qn.push_back(n);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input string n);
      note(2'd0, e, m, n);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic pchk(input logic [1:0] s, input logic [31:0] e, input string n);
      note(s, e, 32'hffff_ffff, n);
      @(posedge ref_clk);
      pend <= 1'b1;
      @(posedge ref_clk);
      pend <= 1'b0;
      @(posedge ref_clk);
   endtask

   initial
   begin
      void'($urandom(72));
      spd = 16'($urandom()) | 16'h0100;
      lim = 16'($urandom());
      idle(6);
      resetn <= 1'b1;
      @(posedge ref_clk);
      bus(1'b1, `OFF_CTRL, 32'h3);
      bus(1'b1, `OFF_IRQ_EN, 32'h7);
      bus(1'b1, `OFF_SPDLIM, {16'h0, lim});
      analogSpeedLimit <= spd;
      idle(5);
      pchk(2'd1, {16'h0, spd}, "speedLimitValue");
      speedSelectBit0 <= 1'b1;
      idle(5);
      pchk(2'd1, {16'h0, lim}, "speedLimitValue");
      speedSelectBit0 <= 1'b0;
      motorSpeed <= spd;
      idle(5);
      rd(`OFF_STATUS, 32'h10, 32'h10, "limiting");
      motorSpeed <= spd - 16'h1;
      idle(5);
      rd(`OFF_STATUS, 32'h0, 32'h10, "limiting");
      speedSelectBit0 <= 1'b1;
      motorSpeed <= lim;
      idle(5);
      rd(`OFF_STATUS, 32'h10, 32'h10, "limiting internal");
      speedSelectBit0 <= 1'b0;
      $display("test speed limit done");
      zeroSpeedFlag <= 1'b0;
      controlModeSwitch <= 1'b1;
      idle(5);
      zeroSpeedFlag <= 1'b1;
      idle(5);
      rd(`OFF_STATUS, 32'h0, 32'h1, "positionMode");
      controlModeSwitch <= 1'b0;
      idle(5);
      controlModeSwitch <= 1'b1;
      idle(5);
      rd(`OFF_STATUS, 32'h1, 32'h1, "positionMode");
      bus(1'b1, `OFF_CMD, 32'h2);
      rd(`OFF_STATUS, 32'h4, 32'h4, "homeValid");
      bus(1'b1, `OFF_IRQ_CLR, 32'h7);
      controlModeSwitch <= 1'b0;
      idle(5);
      rd(`OFF_STATUS, 32'h0, 32'h1, "positionMode");
      rd(`OFF_IRQ_STAT, 32'h4, 32'h4, "mode irq");
      pchk(2'd3, 32'h1, "droop pulses");
      $display("test mode change done");
      wantOn <= 1'b1;
      idle(10);
      for (i = 0; i < 5; i++)
      begin
         cause <= 5'(1 << i);
         idle(3);
         rd(`OFF_STATUS, {16'h0, codes[i], 8'h02}, 32'hff0e, "alarm");
         alarmResetInput <= 1'b1;
         idle(4);
         alarmResetInput <= 1'b0;
         idle(3);
         rd(`OFF_STATUS, 32'h2, 32'h2, "alarm held");
         cause <= 5'h0;
         if (i[0])
            bus(1'b1, `OFF_CMD, 32'h1);
         else
         begin
            alarmResetInput <= 1'b1;
            idle(4);
            alarmResetInput <= 1'b0;
         end
         idle(10);
         rd(`OFF_STATUS, 32'h8, 32'ha, "alarm cleared");
      end
      pchk(2'd2, 32'h1, "irq");
      bus(1'b1, `OFF_IRQ_EN, 32'h0);
      idle(2);
      pchk(2'd2, 32'h0, "irq masked");
      bus(1'b1, `OFF_IRQ_CLR, 32'h7);
      rd(`OFF_IRQ_STAT, 32'h0, 32'h7, "irq status");
      rd(8'h1c, 32'h0, 32'hffff_ffff, "unmapped");
      $display("test alarms done");
      ctrlPowerGood <= 1'b0;
      idle(10);
      ctrlPowerGood <= 1'b1;
      idle(3);
      rd(`OFF_STATUS, 32'h0, 32'h2, "short outage");
      ctrlPowerGood <= 1'b0;
      idle(25);
      ctrlPowerGood <= 1'b1;
      idle(3);
      rd(`OFF_STATUS, 32'h1002, 32'hff02, "outage alarm");
      resetn <= 1'b0;
      idle(2);
      resetn <= 1'b1;
      idle(2);
      rd(`OFF_STATUS, 32'h0, 32'h2, "power cycle clear");
      $display("test supply done");
      test_done();
   end
endmodule
`default_nettype wire
